// ---- atws_slave_port.sv ----
/*
 * Two-wire slave port of the accelerometer. The link side oversamples
 * SCL and SDA on link_clk, decodes start, stop, address, register index
 * and data, and hands each register access over a toggle handshake to
 * the system clock side, which issues it to the register file.
 * Assumes reg_rdata is valid in the same cycle as reg_req_valid, link_clk
 * is far faster than SCL, and the master never stretches or exceeds
 * the fast rate. The port does not stretch SCL.
 */
`timescale 1ns/100ps
`default_nettype none

module atws_slave_port (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              link_clk,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output var  logic              sda_out,
	output var  logic              sda_oe_n,
	input  wire logic              cs_in,
	input  wire logic              slave_address_select_pin,
	output var  atws_pkg::atws_req_t reg_req,
	output var  logic              reg_req_valid,
	input  wire logic [7:0]        reg_rdata
);
	import atws_pkg::*;

	// ------------------------------------------------------------------
	// Link domain declarations
	// ------------------------------------------------------------------
	logic          lrst;           // Reset brought into link domain
	logic [3:0]    pins_s;         // Synced cs, select, scl, sda
	logic          cs_s;           // Synced chip select
	logic          asel_s;         // Synced address select
	logic          scl_s;          // Synced SCL
	logic          sda_s;          // Synced SDA
	logic          scl_d_reg;      // SCL one link cycle earlier
	logic          sda_d_reg;      // SDA one link cycle earlier
	logic          scl_rise;       // SCL rising edge
	logic          scl_fall;       // SCL falling edge
	logic          start_ev;       // Start or repeated start
	logic          stop_ev;        // Stop condition
	atws_state_t   state_reg;      // Link state
	atws_kind_t    kind_reg;       // Meaning of byte being received
	logic [2:0]    bit_cnt_reg;    // Bit position in current byte
	logic [7:0]    shift_reg;      // Receive / transmit shifter
	logic [7:0]    rx_byte;        // Byte completed on this rise
	logic [6:0]    my_addr;        // Address selected by pin
	logic          rd_mode_reg;    // Current transfer is a read
	logic [7:0]    ptr_reg;        // Register pointer
	logic          req_tgl_reg;    // Toggles once per register access
	atws_req_t     req_hold_reg;   // Access held stable for crossing
	logic          ack_s;          // Synced answer toggle
	logic          ack_d_reg;      // Answer toggle one cycle earlier
	logic [7:0]    tx_byte_reg;    // Read data ready for sending
	logic          sda_oe_n_reg;   // Open-drain enable, low pulls SDA
	logic          addr_done;      // Address byte complete this cycle

	// ------------------------------------------------------------------
	// System domain declarations
	// ------------------------------------------------------------------
	logic          req_s;          // Synced request toggle
	logic          req_d_reg;      // Request toggle one cycle earlier
	logic          req_edge;       // New access arrived
	logic          ack_tgl_reg;    // Toggles when access is answered
	logic [7:0]    rdata_reg;      // Read data held for crossing
	atws_req_t     reg_req_reg;    // Access presented to registers
	logic          req_valid_reg;  // One-cycle access strobe
	logic          sda_out_reg;    // Open-drain data level, always low

	// ------------------------------------------------------------------
	// Link domain synchronisers
	// ------------------------------------------------------------------
	// Reset into link domain
	atws_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
		.clk (link_clk),
		.rst (1'b0),
		.d   (sys_rst),
		.q   (lrst)
	);

	// Pins into link domain
	// Oversampling on link_clk follows SCL at either bus rate
	atws_sync #(.W(4), .RST_VAL(PIN_RST)) u_pin_sync (
		.clk (link_clk),
		.rst (lrst),
		.d   ({cs_in, slave_address_select_pin, scl_in, sda_in}),
		.q   (pins_s)
	);

	// Answer toggle into link domain
	atws_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
		.clk (link_clk),
		.rst (lrst),
		.d   (ack_tgl_reg),
		.q   (ack_s)
	);

	assign cs_s   = pins_s[3];
	assign asel_s = pins_s[2];
	assign scl_s  = pins_s[1];
	assign sda_s  = pins_s[0];

	// ------------------------------------------------------------------
	// Bus event detection
	// ------------------------------------------------------------------
	// Previous pin levels for edge detection
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign rx_byte  = {shift_reg[6:0], sda_s};
	assign my_addr  = asel_s ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
	assign addr_done = (state_reg == ST_RX) && scl_rise && (bit_cnt_reg == BIT_LAST)
		&& (kind_reg == K_ADDR) && cs_s && !stop_ev && !start_ev;

	// ------------------------------------------------------------------
	// Link state machine, pointer and request issue
	// ------------------------------------------------------------------
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			state_reg    <= ST_IDLE;
			kind_reg     <= K_ADDR;
			bit_cnt_reg  <= 3'h0;
			shift_reg    <= BYTE_RST;
			rd_mode_reg  <= 1'b0;
			ptr_reg      <= PTR_RST;
			req_tgl_reg  <= 1'b0;
			req_hold_reg <= '0;
			sda_oe_n_reg <= 1'b1;
		end else if (!cs_s || stop_ev) begin
			// Deselected or stop: release bus and wait for start
			state_reg    <= ST_IDLE;
			sda_oe_n_reg <= 1'b1;
		end else if (start_ev) begin
			// Start or repeated start: expect slave address
			state_reg    <= ST_RX;
			kind_reg     <= K_ADDR;
			bit_cnt_reg  <= 3'h0;
			rd_mode_reg  <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else begin
			case (state_reg)
				// Shift a byte in on SCL rising edges
				ST_RX: begin
					if (scl_rise) begin
						shift_reg   <= rx_byte;
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == BIT_LAST) begin
							case (kind_reg)
								// Address byte: ack only our own address
								K_ADDR: begin
									if (rx_byte[7:1] == my_addr) begin
										rd_mode_reg <= rx_byte[RW_BIT];
										kind_reg    <= K_REG;
										state_reg   <= ST_ACKW;
										if (rx_byte[RW_BIT]) begin
											// Fetch first read byte
											req_tgl_reg  <= ~req_tgl_reg;
											req_hold_reg <= '{write: 1'b0, addr: ptr_reg,
												wdata: BYTE_RST};
											ptr_reg      <= ptr_reg + 8'h01;
										end
									end else begin
										state_reg <= ST_IDLE;
									end
								end
								// Register index loads the pointer
								K_REG: begin
									ptr_reg   <= rx_byte;
									kind_reg  <= K_DATA;
									state_reg <= ST_ACKW;
								end
								// Data byte: write and advance
								default: begin
									req_tgl_reg  <= ~req_tgl_reg;
									req_hold_reg <= '{write: 1'b1, addr: ptr_reg,
										wdata: rx_byte};
									ptr_reg      <= ptr_reg + 8'h01;
									state_reg    <= ST_ACKW;
								end
							endcase
						end
					end
				end
				// Pull SDA low for the ack bit
				ST_ACKW: begin
					if (scl_fall) begin
						sda_oe_n_reg <= 1'b0;
						state_reg    <= ST_ACK_TX;
					end
				end
				// End of ack: send read data or receive next byte
				ST_ACK_TX: begin
					if (scl_fall) begin
						bit_cnt_reg <= 3'h0;
						if (rd_mode_reg) begin
							sda_oe_n_reg <= tx_byte_reg[7];
							shift_reg    <= {tx_byte_reg[6:0], 1'b1};
							state_reg    <= ST_TX;
						end else begin
							sda_oe_n_reg <= 1'b1;
							state_reg    <= ST_RX;
						end
					end
				end
				// Shift read data out on SCL falling edges
				ST_TX: begin
					if (scl_fall) begin
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == BIT_LAST) begin
							sda_oe_n_reg <= 1'b1;
							state_reg    <= ST_ACK_RX;
						end else begin
							sda_oe_n_reg <= shift_reg[7];
							shift_reg    <= {shift_reg[6:0], 1'b1};
						end
					end
				end
				// Master ack fetches next byte, NACK ends the read
				ST_ACK_RX: begin
					if (scl_rise) begin
						if (!sda_s) begin
							req_tgl_reg  <= ~req_tgl_reg;
							req_hold_reg <= '{write: 1'b0, addr: ptr_reg, wdata: BYTE_RST};
							ptr_reg      <= ptr_reg + 8'h01;
							state_reg    <= ST_ACK_TX;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				// Idle: only a start leaves this state
				default: begin
					sda_oe_n_reg <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Read data capture on answer toggle
	// ------------------------------------------------------------------
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			ack_d_reg   <= 1'b0;
			tx_byte_reg <= BYTE_RST;
		end else begin
			ack_d_reg <= ack_s;
			if (ack_s != ack_d_reg) begin
				tx_byte_reg <= rdata_reg;      // Stable since before toggle
			end
		end
	end

	// ------------------------------------------------------------------
	// System domain: issue access and answer
	// ------------------------------------------------------------------
	atws_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
		.clk (clk),
		.rst (sys_rst),
		.d   (req_tgl_reg),
		.q   (req_s)
	);

	assign req_edge = req_s ^ req_d_reg;

	// Strobe the held access onto the register port
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_d_reg     <= 1'b0;
			req_valid_reg <= 1'b0;
			reg_req_reg   <= '0;
		end else begin
			req_d_reg     <= req_s;
			req_valid_reg <= req_edge;
			if (req_edge) begin
				reg_req_reg <= req_hold_reg;
			end
		end
	end

	// Capture read data and toggle the answer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_reg   <= BYTE_RST;
			ack_tgl_reg <= 1'b0;
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
			if (req_valid_reg) begin
				rdata_reg   <= reg_rdata;
				ack_tgl_reg <= ~ack_tgl_reg;
			end
		end
	end

	assign reg_req       = reg_req_reg;
	assign reg_req_valid = req_valid_reg;
	assign sda_oe_n      = sda_oe_n_reg;
	assign sda_out       = sda_out_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_deselect_release;
		@(posedge link_clk) disable iff (lrst) !cs_s |=> sda_oe_n_reg && state_reg == ST_IDLE;
	endproperty
	a_deselect_release: assert property (p_deselect_release) else $error("bus held off-select");

	property p_addr_high;
		@(posedge link_clk) disable iff (lrst)
			addr_done && asel_s && rx_byte[7:1] == 7'h1D |=> state_reg == ST_ACKW;
	endproperty
	a_addr_high: assert property (p_addr_high) else $error("address 1D not acked");

	property p_addr_low;
		@(posedge link_clk) disable iff (lrst)
			addr_done && !asel_s && rx_byte[7:1] == 7'h53 |=> state_reg == ST_ACKW;
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("address 53 not acked");

	property p_foreign_addr;
		@(posedge link_clk) disable iff (lrst)
			addr_done && rx_byte[7:1] != my_addr |=> state_reg == ST_IDLE && sda_oe_n_reg;
	endproperty
	a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acked");

	property p_ack_drive;
		@(posedge link_clk) disable iff (lrst)
			state_reg == ST_ACKW && scl_fall && cs_s && !stop_ev && !start_ev
			|=> !sda_oe_n_reg && state_reg == ST_ACK_TX;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

	property p_ptr_step;
		@(posedge link_clk) disable iff (lrst)
			req_tgl_reg != $past(req_tgl_reg) |-> ptr_reg == $past(ptr_reg) + 8'h01;
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

	property p_nack_ends;
		@(posedge link_clk) disable iff (lrst)
			state_reg == ST_ACK_RX && scl_rise && sda_s && cs_s && !stop_ev && !start_ev
			|=> state_reg == ST_IDLE ##1 sda_oe_n_reg;
	endproperty
	a_nack_ends: assert property (p_nack_ends) else $error("read went on after NACK");

	property p_strobe_once;
		@(posedge clk) disable iff (sys_rst)
			req_edge |=> req_valid_reg ##1 !req_valid_reg;
	endproperty
	a_strobe_once: assert property (p_strobe_once) else $error("access strobe not single");

	property p_answer;
		@(posedge clk) disable iff (sys_rst)
			req_valid_reg |=> ack_tgl_reg != $past(ack_tgl_reg) && rdata_reg == $past(reg_rdata);
	endproperty
	a_answer: assert property (p_answer) else $error("access not answered");

endmodule

`default_nettype wire

// ---- atws_pkg.sv ----
/*
 * Shared constants and types of the accelerometer two-wire slave port:
 * slave addresses, reset values, state and byte-kind encodings and the
 * register request that crosses from the link logic to the system side.
 * Assumes a SystemVerilog compiler; the package depends on nothing else.
 */
`default_nettype none

package atws_pkg;

	// ------------------------------------------------------------------
	// Slave addresses and bus facts
	// ------------------------------------------------------------------
	localparam logic [6:0] ADDR_SEL_HIGH  = 7'h1D;   // Address with select pin high
	localparam logic [6:0] ADDR_SEL_LOW   = 7'h53;   // Address with select pin grounded
	localparam int         RATE_STD_KHZ   = 100;     // Standard bus rate
	localparam int         RATE_FAST_KHZ  = 400;     // Fast bus rate, upper limit
	localparam int         CLK_PERIOD_NS  = 25;      // System clock, 40 MHz
	localparam int         FAST_SCL_NS    = 1000000 / RATE_FAST_KHZ;
	// Fewest system clocks in one fast SCL period (rounded down)
	localparam int         FAST_SCL_CYC   = FAST_SCL_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------------
	localparam logic [2:0] BIT_LAST       = 3'h7;    // Index of eighth bit in a byte
	localparam logic [7:0] PTR_RST        = 8'h00;   // Register pointer after reset
	localparam logic [7:0] BYTE_RST       = 8'hFF;   // Idle byte value
	localparam int         RW_BIT         = 0;       // Direction bit in address byte
	localparam logic [3:0] PIN_RST        = 4'hF;    // Pins idle high after reset

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	// Link state, Gray coded along receive, ack, send path
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_RX     = 3'h1,
		ST_ACKW   = 3'h3,
		ST_ACK_TX = 3'h2,
		ST_TX     = 3'h6,
		ST_ACK_RX = 3'h7
	} atws_state_t;

	// Meaning of the byte being received
	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_REG  = 2'h1,
		K_DATA = 2'h2
	} atws_kind_t;

	// One register access towards the sensor registers
	typedef struct packed {
		logic       write;   // High for a write, low for a read
		logic [7:0] addr;    // Register index
		logic [7:0] wdata;   // Write data, don't care on reads
	} atws_req_t;

endpackage

`default_nettype wire

// ---- atws_sync.sv ----
/*
 * Two flip-flop synchroniser for a group of levels entering a clock
 * domain. Assumes each bit is an independent level or a toggle; buses
 * of dependent bits must not be passed through it.
 */
`timescale 1ns/100ps
`default_nettype none

module atws_sync #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [W-1:0]  d,
	output var  logic [W-1:0]  q
);

	logic [W-1:0] meta_reg;   // First stage, read only by second stage

	// ------------------------------------------------------------------
	// Two stages, synchronous reset to a constant
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= RST_VAL;
			q        <= RST_VAL;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// ---- atws_i2c_master_model.sv ----
/*
 * Behavioural two-wire bus master that drives SCL and its own share of
 * SDA, and samples the resolved SDA line.
 * Assumes an external pull-up resolves SDA and that the caller sets the
 * quarter-bit length in system clocks before each transfer.
 */
`timescale 1ns/100ps
`default_nettype none

module atws_i2c_master_model (
	input  wire logic clk,
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic sda_drv
);
	// ----------------------------------------------------------------
	// Bit timing
	// ----------------------------------------------------------------
	int q_cyc = 25;    // Quarter bit in clocks; 25 gives 400 kHz, 100 gives 100 kHz

	// Bus idles high with both lines released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// One quarter of a bit period, stepped on falling clock edges
	task automatic quarter();
		repeat (q_cyc) @(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// Bus conditions and bytes
	// ----------------------------------------------------------------
	// Start or repeated start: SDA falls while SCL is high
	task automatic start();
		sda_drv = 1'b1;
		quarter();
		scl = 1'b1;
		quarter();
		sda_drv = 1'b0;
		quarter();
		scl = 1'b0;
		quarter();
	endtask

	// Stop: SDA rises while SCL is high
	task automatic stop();
		sda_drv = 1'b0;
		quarter();
		scl = 1'b1;
		quarter();
		sda_drv = 1'b1;
		quarter();
	endtask

	// Data changes only while SCL is low, sampled mid-high
	task automatic clock_bit(input logic b, output logic s);
		sda_drv = b;
		quarter();
		scl = 1'b1;
		quarter();
		s = sda_line;
		quarter();
		scl = 1'b0;
		quarter();
	endtask

	// Send a byte MSB first, then release SDA for the slave's ack
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b[i], s);
		end
		clock_bit(1'b1, s);
		ack = ~s;
	endtask

	// Receive a byte, then ack it or answer the last one with nack
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, s);
			d[i] = s;
		end
		clock_bit(nack, s);
	endtask
endmodule

`default_nettype wire

// ---- accel_two_wire_slave_port_tb_top.sv ----
/*
 * Self-checking bench of the two-wire slave port: a master model on the
 * bus, a small register file on the register side.
 * Assumes the design answers reads one clock after its request strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module accel_two_wire_slave_port_tb_top;
	import atws_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic       clk;           // System clock, 40 MHz
	logic       link_clk;      // Link clock, 12 ns
	logic       sys_rst;       // Synchronous reset
	logic       cs_in;         // Two-wire mode select
	logic       sel_pin;       // Slave address select
	logic       scl;           // SCL from the master
	logic       sda_m;         // Master share of SDA
	wire        sda_line;      // Resolved SDA
	logic       sda_out;       // Slave drive level
	logic       sda_oe_n;      // Slave drive enable, active low
	atws_req_t  reg_req;       // Register access
	logic       reg_req_valid; // Access strobe
	logic [7:0] reg_rdata;     // Read answer
	logic [7:0] regs [256];    // Bench register file
	int         wcount;        // Register writes seen
	int         rcount;        // Register reads seen
	int         err_total;
	int         samples_checked;

	// Pull-up: low only where some party pulls low
	assign sda_line = sda_m & (sda_oe_n ? 1'b1 : sda_out);

	// Clocks, unrelated in phase
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3.1;
		forever #6 link_clk = ~link_clk;
	end

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	atws_slave_port DUT (
		.clk                      (clk),
		.sys_rst                  (sys_rst),
		.link_clk                 (link_clk),
		.scl_in                   (scl),
		.sda_in                   (sda_line),
		.sda_out                  (sda_out),
		.sda_oe_n                 (sda_oe_n),
		.cs_in                    (cs_in),
		.slave_address_select_pin (sel_pin),
		.reg_req                  (reg_req),
		.reg_req_valid            (reg_req_valid),
		.reg_rdata                (reg_rdata)
	);

	atws_i2c_master_model m (
		.clk      (clk),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_drv  (sda_m)
	);

	// Register file, sampled mid-cycle while the access strobe stands
	always @(negedge clk) begin
		if (reg_req_valid === 1'b1 && reg_req.write === 1'b1) begin
			regs[reg_req.addr] = reg_req.wdata;
			wcount++;
		end else if (reg_req_valid === 1'b1) begin
			reg_rdata <= regs[reg_req.addr];
			rcount++;
		end
	end

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic chk_bit(input string what, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic summarize();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Send one byte and judge the slave's ack
	task automatic tx(input logic [7:0] b, input logic exp_ack);
		logic a;
		m.wbyte(b, a);
		chk_bit("ack", exp_ack, a);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Multi-byte write at the high-select address
	task automatic sc_write_multi();
		int w0;
		w0 = wcount;
		sel_pin = 1'b1;
		m.start();
		tx(8'h3A, 1'b1);
		tx(8'h10, 1'b1);
		tx(8'hA1, 1'b1);
		tx(8'hB2, 1'b1);
		tx(8'hC3, 1'b1);
		m.stop();
		repeat (40) @(negedge clk);
		chk_byte("reg10", 8'hA1, regs[8'h10]);
		chk_byte("reg11", 8'hB2, regs[8'h11]);
		chk_byte("reg12", 8'hC3, regs[8'h12]);
		chk_byte("writes", 8'h03, 8'(wcount - w0));
	endtask

	// Grounded select: old address refused, new one written once
	task automatic sc_write_alt();
		sel_pin = 1'b0;
		repeat (20) @(negedge clk);
		m.start();
		tx(8'h3A, 1'b0);
		m.stop();
		m.start();
		tx(8'hA6, 1'b1);
		tx(8'h20, 1'b1);
		tx(8'h5A, 1'b1);
		m.stop();
		repeat (40) @(negedge clk);
		chk_byte("reg20", 8'h5A, regs[8'h20]);
		chk_byte("reg21", 8'h00, regs[8'h21]);
	endtask

	// Multi-byte read through a repeated start
	task automatic sc_read_multi();
		logic [7:0] d;
		int         w0;
		int         r0;
		w0 = wcount;
		r0 = rcount;
		sel_pin = 1'b1;
		regs[8'h30] = 8'h96;
		regs[8'h31] = 8'h3C;
		regs[8'h32] = 8'hE1;
		repeat (20) @(negedge clk);
		m.start();
		tx(8'h3A, 1'b1);
		tx(8'h30, 1'b1);
		m.start();
		tx(8'h3B, 1'b1);
		m.rbyte(1'b0, d);
		chk_byte("rd0", 8'h96, d);
		m.rbyte(1'b0, d);
		chk_byte("rd1", 8'h3C, d);
		m.rbyte(1'b1, d);
		chk_byte("rd2", 8'hE1, d);
		m.stop();
		repeat (40) @(negedge clk);
		chk_byte("reads", 8'h03, 8'(rcount - r0));
		chk_byte("writes_rd", 8'h00, 8'(wcount - w0));
	endtask

	// Single-byte read at standard rate, stop then start
	task automatic sc_read_slow();
		logic [7:0] d;
		m.q_cyc = 100;
		sel_pin = 1'b0;
		regs[8'h40] = 8'hC5;
		repeat (20) @(negedge clk);
		m.start();
		tx(8'hA6, 1'b1);
		tx(8'h40, 1'b1);
		m.stop();
		m.start();
		tx(8'hA7, 1'b1);
		m.rbyte(1'b1, d);
		chk_byte("rd_slow", 8'hC5, d);
		m.stop();
		m.q_cyc = 25;
	endtask

	// Chip select low: port stays off the bus
	task automatic sc_cs_off();
		int w0;
		w0 = wcount;
		sel_pin = 1'b1;
		cs_in = 1'b0;
		repeat (20) @(negedge clk);
		m.start();
		tx(8'h3A, 1'b0);
		tx(8'h50, 1'b0);
		m.stop();
		repeat (40) @(negedge clk);
		chk_byte("writes_off", 8'h00, 8'(wcount - w0));
		chk_bit("oe_off", 1'b1, sda_oe_n);
		chk_bit("sda_out", 1'b0, sda_out);
		cs_in = 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		cs_in = 1'b1;
		sel_pin = 1'b1;
		reg_rdata = 8'h00;
		wcount = 0;
		rcount = 0;
		err_total = 0;
		samples_checked = 0;
		foreach (regs[i]) regs[i] = 8'h00;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		repeat (20) @(negedge clk);
		sc_write_multi();
		sc_write_alt();
		sc_read_multi();
		sc_read_slow();
		sc_cs_off();
		summarize();
	end

	// Bounded run length
	initial begin
		repeat (95000) @(posedge clk);
		err_total++;
		summarize();
	end
endmodule

`default_nettype wire
